// ===== hdl/sfpb_builder.sv
// Frame payload builder with APB register access and byte-stream output.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sfpb_builder (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ppdu_valid,
    input wire logic [7:0] ppdu_data,
    input wire logic ppdu_first,
    input wire logic [11:0] ppdu_count,
    input wire logic ppdu_none,
    output logic ppdu_ready,
    input wire logic sdu_valid,
    input wire logic [7:0] sdu_data,
    input wire logic sdu_last,
    output logic sdu_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    output logic [2:0] out_bits,
    input wire logic out_ready,
    output logic busy
);

    sfpb_pkg::sfpb_state_t s;
    sfpb_pkg::sfpb_state_t n;
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    logic mapped;
    logic emit;
    logic push;
    logic [7:0] push_data;
    logic [127:0] def_label;
    logic [3:0] def_len;
    logic start;
    sfpb_pkg::sfpb_fsm_t body;

    always_comb begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            if (paddr <= sfpb_pkg::OFF_TAG || (paddr >= sfpb_pkg::OFF_LABEL0 && paddr <= sfpb_pkg::OFF_PSIZE3)) begin
                mapped = 1'b1;
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s.prdata;
    assign out_valid = s.ob.valid;
    assign out_data = s.ob.data;
    assign out_last = s.ob.last;
    assign out_bits = s.ob.bits;
    assign busy = (s.fsm != sfpb_pkg::SFPB_IDLE);

    // Default labels are built from the written configuration, so the start edge latches them whole.
    always_comb begin
        def_label = 128'h0;
        def_len = sfpb_pkg::LBL_NONE;
        if (s.cfg.custom || s.cfg.access == sfpb_pkg::SFPB_ACC_RESERVED
            || s.cfg.content == sfpb_pkg::SFPB_CT_RESERVED) begin
            def_label = s.custom;
            def_len = s.cfg.label_len;
        end else begin
            case (s.cfg.access)
                sfpb_pkg::SFPB_ACC_DEDICATED: begin
                    def_len = sfpb_pkg::LBL_NONE;
                end
                sfpb_pkg::SFPB_ACC_ALOHA: begin
                    if (s.cfg.content == sfpb_pkg::SFPB_CT_LOGON) begin
                        def_label = {s.hwid, 80'h0};
                        def_len = sfpb_pkg::LBL_ALOHA_LOGON;
                    end else begin
                        def_label = {s.gid, s.lid, 104'h0};
                        def_len = sfpb_pkg::LBL_ALOHA;
                    end
                end
                sfpb_pkg::SFPB_ACC_CRDSA: begin
                    if (s.cfg.content == sfpb_pkg::SFPB_CT_LOGON) begin
                        def_label = {s.hwid, s.tag, 64'h0};
                        def_len = sfpb_pkg::LBL_CRDSA_LOGON;
                    end else begin
                        def_label = {s.gid, s.lid, s.tag, 88'h0};
                        def_len = sfpb_pkg::LBL_CRDSA;
                    end
                end
                default: begin
                    def_len = sfpb_pkg::LBL_NONE;
                end
            endcase
        end
    end

    always_comb begin
        n = s;
        ppdu_ready = 1'b0;
        sdu_ready = 1'b0;
        push = 1'b0;
        push_data = sfpb_pkg::PAD_BYTE;
        start = 1'b0;
        emit = !s.ob.valid || out_ready;
        body = (s.act.content == sfpb_pkg::SFPB_CT_TRAFFIC) ? sfpb_pkg::SFPB_PPDU : sfpb_pkg::SFPB_SDU;

        // Read data is captured in the setup phase so the access phase needs no wait state.
        if (psel && !penable && !pwrite) begin
            n.prdata = 32'h00000000;
            case (paddr)
                sfpb_pkg::OFF_STATUS: begin
                    n.prdata[sfpb_pkg::STAT_BUSY] = (s.fsm != sfpb_pkg::SFPB_IDLE);
                    n.prdata[sfpb_pkg::STAT_TRUNC] = s.sdu_trunc;
                    n.prdata[sfpb_pkg::STAT_FRAMES +: 16] = s.frames;
                end
                sfpb_pkg::OFF_CFG: n.prdata[15:0] = s.cfg;
                sfpb_pkg::OFF_HWID_LO: n.prdata = s.hwid[31:0];
                sfpb_pkg::OFF_HWID_HI: n.prdata[15:0] = s.hwid[47:32];
                sfpb_pkg::OFF_IDS: n.prdata[23:0] = {s.lid, s.gid};
                sfpb_pkg::OFF_TAG: n.prdata[15:0] = s.tag;
                default: begin
                    if (mapped && paddr >= sfpb_pkg::OFF_PSIZE0) begin
                        n.prdata[sfpb_pkg::SIZE_W-1:0] = s.psize[paddr[3:2]];
                    end else if (mapped && paddr >= sfpb_pkg::OFF_LABEL0) begin
                        n.prdata = s.custom[~paddr[3:2]];
                    end
                end
            endcase
        end

        if (psel && penable && pwrite && mapped) begin
            case (paddr)
                sfpb_pkg::OFF_CTRL: begin
                    if (pwdata[sfpb_pkg::CTRL_CLR_TRUNC]) begin
                        n.sdu_trunc = 1'b0;
                    end
                    start = pwdata[sfpb_pkg::CTRL_START] && (s.fsm == sfpb_pkg::SFPB_IDLE);
                end
                sfpb_pkg::OFF_CFG: n.cfg = pwdata[15:0];
                sfpb_pkg::OFF_HWID_LO: n.hwid[31:0] = pwdata;
                sfpb_pkg::OFF_HWID_HI: n.hwid[47:32] = pwdata[15:0];
                sfpb_pkg::OFF_IDS: begin
                    n.gid = pwdata[7:0];
                    n.lid = pwdata[23:8];
                end
                sfpb_pkg::OFF_TAG: n.tag = pwdata[15:0];
                default: begin
                    if (paddr >= sfpb_pkg::OFF_PSIZE0) begin
                        n.psize[paddr[3:2]] = pwdata[sfpb_pkg::SIZE_W-1:0];
                    end else if (paddr >= sfpb_pkg::OFF_LABEL0) begin
                        n.custom[~paddr[3:2]] = pwdata;
                    end
                end
            endcase
        end

        if (emit) begin
            n.ob.valid = 1'b0;
        end

        if (start) begin
            n.act = s.cfg;
            n.label = def_label;
            n.lbl_left = def_len;
            n.bytes_left = s.psize[s.cfg.mode][sfpb_pkg::SIZE_W-1:3];
            n.tail = s.psize[s.cfg.mode][2:0];
            n.ppdu_left = 12'h000;
            n.frames = s.frames + 16'h0001;
            if (s.psize[s.cfg.mode][sfpb_pkg::SIZE_W-1:3] == '0) begin
                n.fsm = (s.psize[s.cfg.mode][2:0] != 3'b000) ? sfpb_pkg::SFPB_TAIL : sfpb_pkg::SFPB_IDLE;
            end else if (s.cfg.content == sfpb_pkg::SFPB_CT_TRAFFIC && s.cfg.explicit_map) begin
                n.fsm = sfpb_pkg::SFPB_HDR;
            end else if (def_len != sfpb_pkg::LBL_NONE) begin
                n.fsm = sfpb_pkg::SFPB_LABEL;
            end else begin
                n.fsm = (s.cfg.content == sfpb_pkg::SFPB_CT_TRAFFIC) ? sfpb_pkg::SFPB_PPDU : sfpb_pkg::SFPB_SDU;
            end
        end else if (emit) begin
            case (s.fsm)
                sfpb_pkg::SFPB_HDR: begin
                    push = 1'b1;
                    push_data = {s.lbl_left, s.act.ppdu_label_len};
                    n.fsm = (s.lbl_left != sfpb_pkg::LBL_NONE) ? sfpb_pkg::SFPB_LABEL : body;
                end
                sfpb_pkg::SFPB_LABEL: begin
                    push = 1'b1;
                    push_data = s.label[127:120];
                    n.label = {s.label[119:0], 8'h00};
                    n.lbl_left = s.lbl_left - 4'h1;
                    if (s.lbl_left == 4'h1) begin
                        n.fsm = body;
                    end
                end
                sfpb_pkg::SFPB_PPDU: begin
                    // Ready follows valid, so a high ready pin always marks a byte that was really taken.
                    if (s.ppdu_left != 12'h000) begin
                        if (ppdu_valid) begin
                            ppdu_ready = 1'b1;
                            push = 1'b1;
                            push_data = ppdu_data;
                            n.ppdu_left = s.ppdu_left - 12'h001;
                        end
                    end else if (s.bytes_left == 1) begin
                        n.fsm = sfpb_pkg::SFPB_PAD;
                    end else if (ppdu_valid && ppdu_first) begin
                        // A PPDU that cannot fit whole is left at the source for a later frame.
                        if (ppdu_count >= sfpb_pkg::PPDU_MIN_BYTES
                            && {{(sfpb_pkg::SIZE_W-15){1'b0}}, ppdu_count} <= s.bytes_left) begin
                            ppdu_ready = 1'b1;
                            push = 1'b1;
                            push_data = ppdu_data;
                            n.ppdu_left = ppdu_count - 12'h001;
                        end else begin
                            n.fsm = sfpb_pkg::SFPB_PAD;
                        end
                    end else if (ppdu_valid) begin
                        ppdu_ready = 1'b1;
                    end else if (ppdu_none) begin
                        n.fsm = sfpb_pkg::SFPB_PAD;
                    end
                end
                sfpb_pkg::SFPB_SDU: begin
                    if (sdu_valid) begin
                        sdu_ready = 1'b1;
                        push = 1'b1;
                        push_data = sdu_data;
                        if (sdu_last) begin
                            n.fsm = sfpb_pkg::SFPB_PAD;
                        end else if (s.bytes_left == 1) begin
                            n.sdu_trunc = 1'b1;
                        end
                    end
                end
                sfpb_pkg::SFPB_PAD: begin
                    push = 1'b1;
                    push_data = sfpb_pkg::PAD_BYTE;
                end
                sfpb_pkg::SFPB_TAIL: begin
                    n.ob.valid = 1'b1;
                    n.ob.last = 1'b1;
                    n.ob.bits = s.tail;
                    n.ob.data = sfpb_pkg::PAD_BYTE;
                    n.fsm = sfpb_pkg::SFPB_IDLE;
                end
                default: begin
                    n.fsm = sfpb_pkg::SFPB_IDLE;
                end
            endcase
        end

        // Every frame ends on its byte budget, whatever state the content reached.
        if (push) begin
            n.ob.valid = 1'b1;
            n.ob.data = push_data;
            n.ob.last = (s.bytes_left == 1) && (s.tail == 3'b000);
            n.ob.bits = 3'b000;
            n.bytes_left = s.bytes_left - 1'b1;
            if (s.bytes_left == 1) begin
                n.fsm = (s.tail != 3'b000) ? sfpb_pkg::SFPB_TAIL : sfpb_pkg::SFPB_IDLE;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/sfpb_pkg.sv
// Constants, types and register map of the satellite frame payload builder.
`default_nettype none
package sfpb_pkg;

    localparam int SIZE_W = 19;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_HWID_LO = 8'h0C;
    localparam logic [7:0] OFF_HWID_HI = 8'h10;
    localparam logic [7:0] OFF_IDS = 8'h14;
    localparam logic [7:0] OFF_TAG = 8'h18;
    localparam logic [7:0] OFF_LABEL0 = 8'h20;
    localparam logic [7:0] OFF_LABEL3 = 8'h2C;
    localparam logic [7:0] OFF_PSIZE0 = 8'h30;
    localparam logic [7:0] OFF_PSIZE3 = 8'h3C;

    localparam int CTRL_START = 0;
    localparam int CTRL_CLR_TRUNC = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_TRUNC = 1;
    localparam int STAT_FRAMES = 16;

    localparam logic [3:0] LBL_NONE = 4'h0;
    localparam logic [3:0] LBL_ALOHA_LOGON = 4'h6;
    localparam logic [3:0] LBL_ALOHA = 4'h3;
    localparam logic [3:0] LBL_CRDSA_LOGON = 4'h8;
    localparam logic [3:0] LBL_CRDSA = 4'h5;

    localparam logic [11:0] PPDU_MIN_BYTES = 12'h002;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    localparam logic [SIZE_W-1:0] PSIZE_RST = 19'h00000;

    typedef enum logic [1:0] {
        SFPB_ACC_DEDICATED = 2'b00,
        SFPB_ACC_ALOHA = 2'b01,
        SFPB_ACC_CRDSA = 2'b10,
        SFPB_ACC_RESERVED = 2'b11
    } sfpb_access_t;

    typedef enum logic [1:0] {
        SFPB_CT_LOGON = 2'b00,
        SFPB_CT_CONTROL = 2'b01,
        SFPB_CT_TRAFFIC = 2'b10,
        SFPB_CT_RESERVED = 2'b11
    } sfpb_content_t;

    typedef enum logic [2:0] {
        SFPB_IDLE = 3'b000,
        SFPB_HDR = 3'b001,
        SFPB_LABEL = 3'b010,
        SFPB_PPDU = 3'b011,
        SFPB_SDU = 3'b100,
        SFPB_PAD = 3'b101,
        SFPB_TAIL = 3'b110
    } sfpb_fsm_t;

    // Bit 0 is explicit_map, bit 15 the top of mode.
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] ppdu_label_len;
        logic [3:0] label_len;
        sfpb_content_t content;
        sfpb_access_t access;
        logic custom;
        logic explicit_map;
    } sfpb_cfg_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [2:0] bits;
        logic [7:0] data;
    } sfpb_byte_t;

    typedef struct packed {
        sfpb_fsm_t fsm;
        sfpb_cfg_t cfg;
        sfpb_cfg_t act;
        logic [47:0] hwid;
        logic [7:0] gid;
        logic [15:0] lid;
        logic [15:0] tag;
        logic [3:0][31:0] custom;
        logic [3:0][SIZE_W-1:0] psize;
        logic [127:0] label;
        logic [3:0] lbl_left;
        logic [SIZE_W-4:0] bytes_left;
        logic [2:0] tail;
        logic [11:0] ppdu_left;
        logic sdu_trunc;
        logic [15:0] frames;
        sfpb_byte_t ob;
        logic [31:0] prdata;
    } sfpb_state_t;

endpackage
`default_nettype wire

// ===== test/sfpb_monitor.sv
// Port-level checker for the frame payload builder.
`timescale 1ns/1ps
`default_nettype none
module sfpb_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ppdu_valid,
    input wire logic ppdu_ready,
    input wire logic sdu_valid,
    input wire logic sdu_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic [2:0] out_bits,
    input wire logic out_ready,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_start;
        psel && penable && pwrite && paddr == sfpb_pkg::OFF_CTRL && pwdata[0] && !busy;
    endsequence
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    a_apb_ready: assert property (psel && penable |-> pready) else $error("pready low in access");
    a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr) else $error("no slverr");
    a_cfg_addr: assert property (psel && penable && paddr == sfpb_pkg::OFF_CFG |-> !pslverr) else $error("bad slverr");
    // The first byte is registered one edge after the frame state moves, so it shows two edges after start.
    a_first_byte: assert property (s_start |-> ##2 out_valid) else $error("no byte after start");
    a_out_hold: assert property (s_stall |=> out_valid && $stable(out_data) && $stable(out_bits)) else $error("unheld");
    a_tail_zero: assert property (out_valid && out_bits != 3'h0 |-> out_data == 8'h00 && out_last) else $error("tail");
    a_bits_last: assert property (out_valid && !out_last |-> out_bits == 3'h0) else $error("early partial");
    a_ppdu_take: assert property (ppdu_ready |-> ppdu_valid && busy) else $error("ppdu taken idle");
    a_sdu_take: assert property (sdu_ready |-> sdu_valid && busy && !ppdu_ready) else $error("sdu taken");
    a_stop_last: assert property (out_valid && out_ready && out_last |=> !out_valid) else $error("byte after last");
endmodule
bind sfpb_builder sfpb_monitor u_mon (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .ppdu_valid, .ppdu_ready, .sdu_valid, .sdu_ready, .out_valid, .out_data, .out_last, .out_bits,
    .out_ready, .busy);
`default_nettype wire

// ===== test/sfpb_sink.sv
// Burst formatter model that records the byte stream and can stall.
`timescale 1ns/1ps
`default_nettype none
module sfpb_sink (
    input wire logic clock,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic [2:0] out_bits,
    output logic out_ready
);
    logic [7:0] cap [0:127];
    logic lst [0:127];
    logic [2:0] bts [0:127];
    logic [1:0] ph = 2'b00;
    int n = 0;
    // Bytes are kept raw; a lone trailing byte or zero run is never parsed as a PPDU.
    always @(posedge clock) begin
        ph <= ph + 2'b01;
        out_ready <= !stall || ph == 2'b11;
        if (out_valid && out_ready) begin
            cap[n] <= out_data;
            lst[n] <= out_last;
            bts[n] <= out_bits;
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the frame payload builder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module testbench;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ppdu_ready, sdu_ready, out_valid, out_last, out_ready, busy;
    logic [7:0] out_data, ppdu_data, sdu_data;
    logic [2:0] out_bits;
    logic ppdu_valid, ppdu_first, sdu_valid, sdu_last;
    logic [11:0] ppdu_count = 12'h005;
    logic pv = 1'b0;
    logic ppdu_none = 1'b1;
    logic sv = 1'b0;
    logic stall = 1'b0;
    int pidx = 0, sidx = 0, slen = 0, num_errors = 0, tests_run = 0;
    logic [7:0] ex [$];
    always_comb begin
        ppdu_valid = pv;
        ppdu_data = 8'hA1 + 8'(pidx);
        ppdu_first = (pidx % 5 == 0);
        sdu_valid = sv && (sidx < slen);
        sdu_data = 8'hC1 + 8'(sidx);
        sdu_last = (sidx == slen - 1);
    end
    always @(posedge clock) begin
        if (ppdu_valid && ppdu_ready) pidx <= pidx + 1;
        if (sdu_valid && sdu_ready) sidx <= sidx + 1;
    end
    initial begin
        forever #4 clock = ~clock;
    end
    sfpb_builder DUT (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ppdu_valid, .ppdu_data, .ppdu_first, .ppdu_count, .ppdu_none, .ppdu_ready, .sdu_valid, .sdu_data,
        .sdu_last, .sdu_ready, .out_valid, .out_data, .out_last, .out_bits, .out_ready, .busy);
    sfpb_sink snk (.clock, .stall, .out_valid, .out_data, .out_last, .out_bits, .out_ready);
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setup(input logic [31:0] c, input logic [31:0] ps);
        apb(1'b1, sfpb_pkg::OFF_CFG, c);
        apb(1'b1, sfpb_pkg::OFF_PSIZE0 + {4'h0, c[15:14], 2'b00}, ps);
    endtask
    // A mid-frame CFG write must leave the running frame untouched.
    task automatic frame(input int nb, input logic [2:0] eb, input logic [31:0] mid);
        int n0;
        int tot;
        n0 = snk.n;
        tot = nb + int'(eb != 3'h0);
        apb(1'b1, sfpb_pkg::OFF_CTRL, 32'h1);
        if (mid != 32'h0) begin
            apb(1'b1, sfpb_pkg::OFF_CFG, mid);
            apb(1'b0, sfpb_pkg::OFF_STATUS, 32'h0);
            `CHK(rd[sfpb_pkg::STAT_BUSY], 1'b1)
        end
        for (int w = 0; w < 300 && snk.n < n0 + tot; w++) @(posedge clock);
        repeat (2) @(posedge clock);
        `CHK(snk.n, n0 + tot)
        for (int k = 0; k < nb; k++) `CHK(snk.cap[n0 + k], ex[k])
        if (eb != 3'h0) begin
            `CHK(snk.bts[n0 + nb], eb)
            `CHK(snk.cap[n0 + nb], 8'h00)
        end
        `CHK(snk.lst[n0 + tot - 1], 1'b1)
    endtask
    task automatic wrap_up();
        $display("errors %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Whole run needs a few hundred cycles; the limit leaves wide margin.
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, sfpb_pkg::OFF_CFG, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, sfpb_pkg::OFF_HWID_LO, 32'h33445566);
        apb(1'b1, sfpb_pkg::OFF_HWID_HI, 32'h00001122);
        apb(1'b1, sfpb_pkg::OFF_IDS, 32'h00BC4D7A);
        apb(1'b1, sfpb_pkg::OFF_TAG, 32'h00009E2F);
        apb(1'b1, sfpb_pkg::OFF_LABEL0, 32'hD1D20000);
        apb(1'b0, sfpb_pkg::OFF_IDS, 32'h0);
        `CHK(rd, 32'h00BC4D7A)
        setup(32'h4825, 32'd48);
        ex = '{8'h32, 8'h7A, 8'hBC, 8'h4D, 8'h00, 8'h00};
        frame(6, 3'h0, 32'h0);
        pv <= 1'b1;
        ppdu_none <= 1'b0;
        stall <= 1'b1;
        setup(32'h0020, 32'd51);
        ex = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'h00};
        frame(6, 3'h3, 32'h4825);
        stall <= 1'b0;
        setup(32'h40AC, 32'd48);
        ex = '{8'hD1, 8'hD2, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(6, 3'h0, 32'h0);
        pv <= 1'b0;
        ppdu_none <= 1'b1;
        sv <= 1'b1;
        slen <= 3;
        setup(32'h8009, 32'd101);
        ex = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h9E, 8'h2F, 8'hC1, 8'hC2, 8'hC3, 8'h00};
        frame(12, 3'h5, 32'h0);
        setup(32'h0004, 32'd48);
        ex = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
        frame(6, 3'h0, 32'h0);
        slen <= 6;
        setup(32'hC018, 32'd48);
        ex = '{8'h7A, 8'hBC, 8'h4D, 8'h9E, 8'h2F, 8'hC4};
        frame(6, 3'h0, 32'h0);
        apb(1'b0, sfpb_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[sfpb_pkg::STAT_TRUNC], 1'b1)
        `CHK(rd[31:16], 16'h0006)
        `CHK(rd[sfpb_pkg::STAT_BUSY], 1'b0)
        apb(1'b1, sfpb_pkg::OFF_CTRL, 32'h2);
        apb(1'b0, sfpb_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[sfpb_pkg::STAT_TRUNC], 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire
